/* File: hw/rtmc_pkg.sv */
package rtmc_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W      = 8;
  localparam int unsigned DATA_W      = 16;
  localparam logic [7:0]  OFS_CONTROL = 8'h00;
  localparam logic [7:0]  OFS_STATUS  = 8'h04;
  localparam logic [7:0]  OFS_SELFTEST = 8'h08;
  localparam logic [7:0]  OFS_LAST_CMD = 8'h0C;
  localparam logic [7:0]  OFS_VECTOR  = 8'h10;
  localparam logic [4:0]  RST_RT_ADDR = 5'h01;

  // ----------------------------------------------------------------
  // command word and terminal status word fields
  // ----------------------------------------------------------------
  localparam int unsigned CW_TR       = 10;
  localparam logic [4:0]  BCAST_ADDR  = 5'h1F;
  localparam logic [4:0]  SA_MODE_LO  = 5'h00;
  localparam logic [4:0]  SA_MODE_HI  = 5'h1F;
  localparam int unsigned SW_ME       = 10;
  localparam int unsigned SW_BR       = 4;

  // ----------------------------------------------------------------
  // self-test word error fields
  // ----------------------------------------------------------------
  localparam int unsigned BW_LWC      = 5;
  localparam int unsigned BW_HWC      = 6;
  localparam int unsigned BW_ILL      = 7;
  localparam int unsigned BW_TRE      = 8;
  localparam logic [15:0] BW_ERR_MASK = 16'h01E0;

  // ----------------------------------------------------------------
  // upper mode codes
  // ----------------------------------------------------------------
  localparam logic [4:0]  MC_VECTOR   = 5'h10;
  localparam logic [4:0]  MC_SYNC_DATA = 5'h11;
  localparam logic [4:0]  MC_LAST_CMD = 5'h12;
  localparam logic [4:0]  MC_SELFTEST = 5'h13;
  localparam logic [4:0]  MC_SHUTDOWN = 5'h14;
  localparam logic [4:0]  MC_OVERRIDE = 5'h15;

  // ----------------------------------------------------------------
  // timing counts, in device clock cycles
  // ----------------------------------------------------------------
  localparam int unsigned GRANT_CYCLES = 2;
  // request cycle plus two synchroniser stages before the vector is usable
  localparam int unsigned VEC_WAIT_CYCLES = 4;
  localparam int unsigned HAND_CYCLES = 2;

  typedef enum logic [5:0] {
    S_IDLE    = 6'b000001,
    S_COLLECT = 6'b000010,
    S_HAND    = 6'b000100,
    S_VEC     = 6'b001000,
    S_STAT    = 6'b010000,
    S_DATA    = 6'b100000
  } rtmc_state_e;

endpackage

/* File: hw/rtmc_sync.sv */
`timescale 1ns/1ns
module rtmc_sync
  import rtmc_pkg::*;
#(
  parameter int unsigned  W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         CLK,
  input  wire logic         RST,
  input  wire logic [W-1:0] D,
  output logic      [W-1:0] Q
);
  // first stage is read only by the second
  logic [W-1:0] meta;

  always_ff @(posedge CLK) begin
    if (RST) begin
      meta <= RST_VAL;
      Q    <= RST_VAL;
    end else begin
      meta <= D;
      Q    <= meta;
    end
  end
endmodule // rtmc_sync

/* File: hw/rtmc_host_hs.sv */
`timescale 1ns/1ns
module rtmc_host_hs
  import rtmc_pkg::*;
(
  input  wire logic CLK,
  input  wire logic RST,
  input  wire logic STROBE,
  input  wire logic BUSY,
  output logic      GRANT_N,
  output logic      DONE_N
);
  logic [1:0] wait_cnt;

  // wait restarts while the bus is busy, so the grant trails the release
  always_ff @(posedge CLK) begin
    if (RST) begin
      wait_cnt <= 2'h0;
      GRANT_N  <= 1'b1;
    end else if (!STROBE) begin
      wait_cnt <= 2'h0;
      GRANT_N  <= 1'b1;
    end else if (BUSY && GRANT_N) begin
      wait_cnt <= 2'h0;
    end else if (GRANT_N) begin
      if (wait_cnt == 2'(GRANT_CYCLES - 1)) begin
        GRANT_N <= 1'b0;
      end else begin
        wait_cnt <= wait_cnt + 2'h1;
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      DONE_N <= 1'b1;
    end else if (!STROBE) begin
      DONE_N <= 1'b1;
    end else if (!GRANT_N) begin
      DONE_N <= 1'b0;
    end
  end
endmodule // rtmc_host_hs

/* File: hw/rtmc_mode_upper.sv */
`timescale 1ns/1ns
// Operation
// - transmit vector: status, then vector word fetched from subsystem under bus request.
// - invalid command gets no answer and changes nothing.
// - transmit-type code with receive direction: silent, message error plus listed test bits.
// - broadcast vector or test-word code: silent, message error, broadcast, illegal code.
// - sync with data: hand word to subsystem, then status unless broadcast.
// - sync with data: missing word sets low count, extra words high count, silent.
// - sync with data in transmit direction: silent, error, direction error, high count.
// - transmit last command: status unchanged, then the previous valid command word.
// - last command or test word followed by data, not broadcast: silent, message error only.
// - transmit test word: status then test word, test word left untouched.
// - test-word enable strobe marks the test word on the parallel bus.
// - selected shutdown: hand data word, status unless broadcast.
// - override selected shutdown: hand data word, status unless broadcast.
// - shutdown codes with wrong word count: silent, error, illegal, one count bit.
// - shutdown codes in transmit direction: silent, error, illegal, high count.
// - reserved codes answer status unless broadcast; transmit direction with data is an error.
// - reserved codes, receive direction, wrong count: silent, error, high count, illegal.
// - host grant two cycles after strobe, or two after the bus frees.
// - done indication drops within one cycle after the strobe is released.
module rtmc_mode_upper
  import rtmc_pkg::*;
(
  input  wire logic         CLK,
  input  wire logic         RST,
  input  wire logic [7:0]   REG_ADDR,
  input  wire logic [15:0]  REG_WDATA,
  input  wire logic         REG_WR,
  input  wire logic         REG_RD,
  output logic      [15:0]  REG_RDATA,
  input  wire logic         CMD_VALID,
  input  wire logic         CMD_INVALID,
  input  wire logic [15:0]  CMD_WORD,
  input  wire logic         DATA_VALID,
  input  wire logic [15:0]  DATA_WORD,
  input  wire logic         MSG_END,
  output logic              TX_VALID,
  output logic              TX_STATUS,
  output logic      [15:0]  TX_WORD,
  input  wire logic [15:0]  PARALLEL_DATA_BUS_IN,
  output logic      [15:0]  PARALLEL_DATA_BUS_OUT,
  output logic              PARALLEL_DATA_BUS_OE_N,
  output logic              SUBSYSTEM_BUS_REQUEST,
  output logic              SELFTEST_WORD_ENABLE,
  input  wire logic         HOST_ACCESS_STROBE_N,
  output logic              HOST_ACCESS_GRANT_N,
  output logic              HOST_TRANSFER_DONE_N
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  rtmc_state_e  state;
  logic [4:0]   rt_addr;
  logic [1:0]   sw_flags;
  logic [15:0]  selftest_word;
  logic [15:0]  last_cmd;
  logic [15:0]  vector_word;
  logic [4:0]   cur_mc;
  logic         cur_tr;
  logic         cur_bc;
  logic [1:0]   word_cnt;
  logic [15:0]  rx_word;
  logic [1:0]   step_cnt;
  logic [15:0]  pdb_in_s;
  logic         strobe_n_s;
  logic         host_strobe;
  logic         busy;
  logic         eval;
  logic         cmd_take;
  logic         cmd_upper;
  logic         e_me, e_br, e_tre, e_lwc, e_hwc, e_ill, e_ok, e_keep;

  function automatic logic is_mode_cmd(input logic [15:0] w);
    is_mode_cmd = (w[9:5] == SA_MODE_LO) || (w[9:5] == SA_MODE_HI);
  endfunction

  function automatic logic [15:0] status_word(input logic [4:0] a, input logic [1:0] f);
    logic [15:0] s;
    s         = {a, 11'h000};
    s[SW_ME]  = f[1];
    s[SW_BR]  = f[0];
    status_word = s;
  endfunction

  // ----------------------------------------------------------------
  // pin synchronisers and host handshake
  // ----------------------------------------------------------------
  rtmc_sync #(.W(16)) u_pdb_sync (
    .CLK (CLK),
    .RST (RST),
    .D   (PARALLEL_DATA_BUS_IN),
    .Q   (pdb_in_s)
  );

  // the strobe idles high, so its stages reset high and no false strobe follows reset
  rtmc_sync #(.W(1), .RST_VAL(1'b1)) u_strobe_sync (
    .CLK (CLK),
    .RST (RST),
    .D   (HOST_ACCESS_STROBE_N),
    .Q   (strobe_n_s)
  );

  assign host_strobe = !strobe_n_s;
  // the handler owns the internal bus while it talks to the subsystem
  assign busy        = (state == S_HAND) || (state == S_VEC);

  rtmc_host_hs u_host_hs (
    .CLK     (CLK),
    .RST     (RST),
    .STROBE  (host_strobe),
    .BUSY    (busy),
    .GRANT_N (HOST_ACCESS_GRANT_N),
    .DONE_N  (HOST_TRANSFER_DONE_N)
  );

  // ----------------------------------------------------------------
  // command intake
  // ----------------------------------------------------------------
  assign cmd_take  = CMD_VALID && !CMD_INVALID &&
                     ((state == S_IDLE) || (state == S_COLLECT));
  assign cmd_upper = is_mode_cmd(CMD_WORD) && CMD_WORD[4];
  assign eval      = (state == S_COLLECT) && MSG_END && !CMD_VALID;

  // ----------------------------------------------------------------
  // error decode at end of message
  // ----------------------------------------------------------------
  always_comb begin
    e_me = 1'b0; e_br = 1'b0; e_tre = 1'b0;
    e_lwc = 1'b0; e_hwc = 1'b0; e_ill = 1'b0;
    e_ok = 1'b0; e_keep = 1'b0;
    case (cur_mc)
      MC_VECTOR, MC_LAST_CMD, MC_SELFTEST: begin
        if (!cur_tr) begin
          e_me  = 1'b1;
          e_tre = 1'b1;
          e_ill = cur_bc;
          e_br  = cur_bc && (cur_mc != MC_LAST_CMD);
          e_lwc = !(cur_bc && (cur_mc == MC_LAST_CMD));
        end else if (cur_bc) begin
          e_me  = 1'b1;
          e_br  = 1'b1;
          e_ill = 1'b1;
        end else if (word_cnt != 2'h0) begin
          e_me  = 1'b1;
          e_hwc = (cur_mc == MC_VECTOR);
        end else begin
          e_ok   = 1'b1;
          e_keep = (cur_mc != MC_VECTOR);
        end
      end
      MC_SYNC_DATA: begin
        if (cur_tr) begin
          e_me = 1'b1; e_tre = 1'b1; e_hwc = 1'b1; e_br = cur_bc;
        end else if (word_cnt == 2'h0) begin
          e_me = 1'b1; e_lwc = 1'b1;
        end else if (word_cnt != 2'h1) begin
          e_me = 1'b1; e_hwc = 1'b1;
        end else begin
          e_ok = 1'b1; e_br = cur_bc;
        end
      end
      MC_SHUTDOWN, MC_OVERRIDE: begin
        if (cur_tr) begin
          e_me = 1'b1; e_ill = 1'b1; e_hwc = 1'b1; e_br = cur_bc;
          e_tre = cur_bc && (cur_mc == MC_OVERRIDE);
        end else if (word_cnt != 2'h1) begin
          // the two codes assign the count bits the opposite way round
          e_me  = 1'b1; e_ill = 1'b1;
          e_lwc = (word_cnt == 2'h0) ^ (cur_mc == MC_SHUTDOWN);
          e_hwc = !e_lwc;
        end else begin
          e_ok = 1'b1; e_br = cur_bc;
        end
      end
      default: begin
        if (cur_tr ? (word_cnt != 2'h0) : (word_cnt != 2'h1)) begin
          e_me = 1'b1; e_hwc = 1'b1; e_ill = 1'b1;
        end else begin
          e_ok = 1'b1; e_br = cur_bc;
        end
      end
    endcase
  end

  // ----------------------------------------------------------------
  // message capture
  // ----------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (RST) begin
      cur_mc   <= 5'h00;
      cur_tr   <= 1'b0;
      cur_bc   <= 1'b0;
      word_cnt <= 2'h0;
      rx_word  <= 16'h0000;
    end else if (cmd_take && cmd_upper) begin
      cur_mc   <= CMD_WORD[4:0];
      cur_tr   <= CMD_WORD[CW_TR];
      cur_bc   <= (CMD_WORD[15:11] == BCAST_ADDR);
      word_cnt <= 2'h0;
    end else if ((state == S_COLLECT) && DATA_VALID) begin
      if (word_cnt == 2'h0) begin
        rx_word <= DATA_WORD;
      end
      if (word_cnt != 2'h2) begin
        word_cnt <= word_cnt + 2'h1;
      end
    end
  end

  // the stored command is the one before, so a repeat request returns it again
  always_ff @(posedge CLK) begin
    if (RST) begin
      last_cmd <= 16'h0000;
    end else if (cmd_take && !(is_mode_cmd(CMD_WORD) && CMD_WORD[4:0] == MC_LAST_CMD)) begin
      last_cmd <= CMD_WORD;
    end
  end

  // ----------------------------------------------------------------
  // status and self-test words; hardware update wins over a write
  // ----------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (RST) begin
      sw_flags <= 2'h0;
    end else if (eval && !e_keep) begin
      sw_flags <= {e_me, e_br};
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      selftest_word <= 16'h0000;
    end else if (eval && !e_keep) begin
      selftest_word <= (selftest_word & ~BW_ERR_MASK)
                       | (16'(e_lwc) << BW_LWC) | (16'(e_hwc) << BW_HWC)
                       | (16'(e_ill) << BW_ILL) | (16'(e_tre) << BW_TRE);
    end else if (REG_WR && (REG_ADDR == OFS_SELFTEST)) begin
      selftest_word <= REG_WDATA;
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      rt_addr <= RST_RT_ADDR;
    end else if (REG_WR && (REG_ADDR == OFS_CONTROL)) begin
      rt_addr <= REG_WDATA[4:0];
    end
  end

  // ----------------------------------------------------------------
  // register read port
  // ----------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (RST) begin
      REG_RDATA <= 16'h0000;
    end else if (!REG_RD) begin
      REG_RDATA <= 16'h0000;
    end else if (REG_ADDR == OFS_CONTROL) begin
      REG_RDATA <= {11'h000, rt_addr};
    end else if (REG_ADDR == OFS_STATUS) begin
      REG_RDATA <= status_word(rt_addr, sw_flags);
    end else if (REG_ADDR == OFS_SELFTEST) begin
      REG_RDATA <= selftest_word;
    end else if (REG_ADDR == OFS_LAST_CMD) begin
      REG_RDATA <= last_cmd;
    end else if (REG_ADDR == OFS_VECTOR) begin
      REG_RDATA <= vector_word;
    end else begin
      REG_RDATA <= 16'h0000;
    end
  end

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (RST) begin
      state                  <= S_IDLE;
      step_cnt               <= 2'h0;
      vector_word            <= 16'h0000;
      TX_VALID               <= 1'b0;
      TX_STATUS              <= 1'b0;
      TX_WORD                <= 16'h0000;
      PARALLEL_DATA_BUS_OUT  <= 16'h0000;
      PARALLEL_DATA_BUS_OE_N <= 1'b1;
      SUBSYSTEM_BUS_REQUEST  <= 1'b0;
      SELFTEST_WORD_ENABLE   <= 1'b0;
    end else begin
      TX_VALID               <= 1'b0;
      TX_STATUS              <= 1'b0;
      SELFTEST_WORD_ENABLE   <= 1'b0;
      SUBSYSTEM_BUS_REQUEST  <= 1'b0;
      PARALLEL_DATA_BUS_OE_N <= 1'b1;
      case (state)
        S_IDLE, S_COLLECT: begin
          step_cnt <= 2'h0;
          if (cmd_take) begin
            state <= cmd_upper ? S_COLLECT : S_IDLE;
          end else if (eval) begin
            if (!e_ok) begin
              state <= S_IDLE;
            end else if (!cur_tr && (cur_mc != MC_VECTOR) && (cur_mc != MC_LAST_CMD)
                         && (cur_mc != MC_SELFTEST) && (cur_mc[3:0] < 4'h6)) begin
              state <= S_HAND;
            end else if (cur_bc) begin
              state <= S_IDLE;
            end else if (cur_mc == MC_VECTOR) begin
              state <= S_VEC;
            end else begin
              state <= S_STAT;
            end
          end
        end
        // the host holds the bus once granted; wait for it to let go
        S_HAND: begin
          if (HOST_ACCESS_GRANT_N) begin
            PARALLEL_DATA_BUS_OUT  <= rx_word;
            PARALLEL_DATA_BUS_OE_N <= 1'b0;
            SUBSYSTEM_BUS_REQUEST  <= 1'b1;
            step_cnt               <= step_cnt + 2'h1;
            if (step_cnt == 2'(HAND_CYCLES - 1)) begin
              state <= cur_bc ? S_IDLE : S_STAT;
            end
          end
        end
        S_VEC: begin
          if (HOST_ACCESS_GRANT_N) begin
            SUBSYSTEM_BUS_REQUEST <= 1'b1;
            step_cnt              <= step_cnt + 2'h1;
            if (step_cnt == 2'(VEC_WAIT_CYCLES - 1)) begin
              vector_word <= pdb_in_s;
              state       <= S_STAT;
            end
          end
        end
        S_STAT: begin
          TX_VALID  <= 1'b1;
          TX_STATUS <= 1'b1;
          TX_WORD   <= status_word(rt_addr, sw_flags);
          state     <= (cur_tr && (cur_mc < 5'h14)) ? S_DATA : S_IDLE;
        end
        S_DATA: begin
          TX_VALID <= 1'b1;
          state    <= S_IDLE;
          if (cur_mc == MC_VECTOR) begin
            TX_WORD <= vector_word;
          end else if (cur_mc == MC_LAST_CMD) begin
            TX_WORD <= last_cmd;
          end else begin
            TX_WORD                <= selftest_word;
            PARALLEL_DATA_BUS_OUT  <= selftest_word;
            PARALLEL_DATA_BUS_OE_N <= 1'b0;
            SELFTEST_WORD_ENABLE   <= 1'b1;
          end
        end
        default: begin
          state <= S_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  a_invalid_ignored: assert property (
    CMD_VALID && CMD_INVALID && (state == S_IDLE) |=> (state == S_IDLE) && $stable(sw_flags))
    else $error("invalid command changed state");

  a_vector_order: assert property (
    (state == S_STAT) && (cur_mc == MC_VECTOR) |=>
      TX_VALID && TX_STATUS ##1 TX_VALID && !TX_STATUS && (TX_WORD == vector_word))
    else $error("vector not sent after status");

  a_error_silent: assert property (
    eval && !e_ok |=> !TX_VALID [*3])
    else $error("reply sent after error");

  a_bcast_flags: assert property (
    eval && cur_bc && cur_tr && (cur_mc == MC_SELFTEST) |=>
      sw_flags == 2'h3 && selftest_word[BW_ILL])
    else $error("broadcast test word flags wrong");

  a_sync_count: assert property (
    eval && (cur_mc == MC_SYNC_DATA) && !cur_tr && (word_cnt == 2'h0) |=>
      sw_flags[1] && selftest_word[BW_LWC] && !selftest_word[BW_HWC])
    else $error("missing sync word flags wrong");

  a_last_keeps: assert property (
    eval && e_ok && (cur_mc == MC_LAST_CMD) |=> $stable(sw_flags) ##1 TX_VALID ##1
      TX_VALID && (TX_WORD == last_cmd))
    else $error("last command flow wrong");

  a_selftest_strobe: assert property (
    SELFTEST_WORD_ENABLE |-> TX_VALID && !TX_STATUS && !PARALLEL_DATA_BUS_OE_N &&
      (PARALLEL_DATA_BUS_OUT == TX_WORD))
    else $error("test word strobe without test word");

  a_shut_hand: assert property (
    eval && e_ok && (cur_mc == MC_SHUTDOWN) |=> (state == S_HAND) ##[1:20]
      (SUBSYSTEM_BUS_REQUEST && (PARALLEL_DATA_BUS_OUT == rx_word)))
    else $error("shutdown word not handed over");

  a_grant_delay: assert property (
    $rose(host_strobe) && !busy ##1 host_strobe && !busy |=> !HOST_ACCESS_GRANT_N)
    else $error("grant not two cycles after strobe");

  a_done_release: assert property (
    !host_strobe |=> HOST_TRANSFER_DONE_N && HOST_ACCESS_GRANT_N)
    else $error("done stayed after strobe release");

  c_vector_reply: cover property ((state == S_DATA) && (cur_mc == MC_VECTOR));
  c_sync_bcast:   cover property (eval && e_ok && cur_bc && (cur_mc == MC_SYNC_DATA));
  c_host_grant:   cover property ($fell(HOST_ACCESS_GRANT_N));
  c_reserved_ok:  cover property (eval && e_ok && (cur_mc > MC_OVERRIDE));

endmodule // rtmc_mode_upper

/* File: sim/rtmc_subsys_model.sv */
`timescale 1ns/1ns
// --------------------------------
// subsystem side of the data bus
// --------------------------------
module rtmc_subsys_model (
  input  wire logic        clk,
  input  wire logic [15:0] bus_out,
  input  wire logic        bus_oe_n,
  input  wire logic        bus_req,
  input  wire logic        test_en,
  input  wire logic [15:0] vector,
  output logic      [15:0] bus_level,
  output logic      [15:0] handed,
  output logic      [15:0] test_latch
);
  logic [15:0] drift = 16'hA5C3;
  // an undriven bus wanders, so a stale value never passes
  always @(posedge clk) drift <= ~drift + 16'h0101;
  assign bus_level = !bus_oe_n ? bus_out : bus_req ? vector : drift;
  always @(posedge clk) begin
    if (bus_req && !bus_oe_n) handed <= bus_out;
    if (test_en) test_latch <= bus_level;
  end
endmodule // rtmc_subsys_model

/* File: sim/rtmc_mode_upper_tb.sv */
`timescale 1ns/1ns
module rtmc_mode_upper_tb;
  import rtmc_pkg::*;
  localparam logic [15:0] TRE = 16'h0001 << BW_TRE;
  localparam logic [15:0] LWC = 16'h0001 << BW_LWC;
  localparam logic [15:0] HWC = 16'h0001 << BW_HWC;
  localparam logic [15:0] ILL = 16'h0001 << BW_ILL;
  logic CLK = 1'b0, RST = 1'b1, REG_WR = 1'b0, REG_RD = 1'b0, MSG_END = 1'b0;
  logic CMD_VALID = 1'b0, CMD_INVALID = 1'b0, DATA_VALID = 1'b0, HOST_ACCESS_STROBE_N = 1'b1;
  logic [7:0]  REG_ADDR = 8'h00;
  logic [15:0] REG_WDATA = 16'h0000, CMD_WORD = 16'h0000, DATA_WORD = 16'h0000, vec = 16'h0000;
  logic [15:0] REG_RDATA, TX_WORD, PARALLEL_DATA_BUS_OUT, bus_level, handed, test_latch;
  logic        TX_VALID, TX_STATUS, PARALLEL_DATA_BUS_OE_N, SUBSYSTEM_BUS_REQUEST;
  logic        SELFTEST_WORD_ENABLE, HOST_ACCESS_GRANT_N, HOST_TRANSFER_DONE_N;
  logic [16:0] txq[$];
  int          err_total = 0, samples_checked = 0, en_cnt = 0, tn = 0;
  integer      seed = 32'h8c22cf19;
  always #4 CLK = ~CLK;
  rtmc_mode_upper rtmc_mode_upper_inst (.CLK(CLK), .RST(RST), .REG_ADDR(REG_ADDR),
    .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
    .CMD_VALID(CMD_VALID), .CMD_INVALID(CMD_INVALID), .CMD_WORD(CMD_WORD),
    .DATA_VALID(DATA_VALID), .DATA_WORD(DATA_WORD), .MSG_END(MSG_END), .TX_VALID(TX_VALID),
    .TX_STATUS(TX_STATUS), .TX_WORD(TX_WORD), .PARALLEL_DATA_BUS_IN(bus_level),
    .PARALLEL_DATA_BUS_OUT(PARALLEL_DATA_BUS_OUT), .PARALLEL_DATA_BUS_OE_N(PARALLEL_DATA_BUS_OE_N),
    .SUBSYSTEM_BUS_REQUEST(SUBSYSTEM_BUS_REQUEST), .SELFTEST_WORD_ENABLE(SELFTEST_WORD_ENABLE),
    .HOST_ACCESS_STROBE_N(HOST_ACCESS_STROBE_N), .HOST_ACCESS_GRANT_N(HOST_ACCESS_GRANT_N),
    .HOST_TRANSFER_DONE_N(HOST_TRANSFER_DONE_N));
  rtmc_subsys_model rtmc_subsys_model_inst (.clk(CLK), .bus_out(PARALLEL_DATA_BUS_OUT),
    .bus_oe_n(PARALLEL_DATA_BUS_OE_N), .bus_req(SUBSYSTEM_BUS_REQUEST),
    .test_en(SELFTEST_WORD_ENABLE), .vector(vec), .bus_level(bus_level), .handed(handed),
    .test_latch(test_latch));
  // --------------------------------
  // collection, comparison, bus tasks
  // --------------------------------
  always @(posedge CLK) begin
    if (TX_VALID === 1'b1) txq.push_back({TX_STATUS, TX_WORD});
    if (SELFTEST_WORD_ENABLE === 1'b1) en_cnt++;
  end
  function automatic logic [15:0] cw(input logic [4:0] a, input logic tr, input logic [4:0] mc);
    return {a, tr, SA_MODE_LO, mc};
  endfunction
  function automatic logic [15:0] sw(input logic me, input logic br);
    return {RST_RT_ADDR, me, 5'h00, br, 4'h0};
  endfunction
  task automatic chk(input logic [16:0] got, input logic [16:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic fin;
    tn++;
    $display("test %0d done", tn);
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge CLK);
    REG_WR <= 1'b1;
    REG_ADDR <= a;
    REG_WDATA <= d;
    @(posedge CLK);
    REG_WR <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [15:0] e, input logic [15:0] m);
    @(posedge CLK);
    REG_RD <= 1'b1;
    REG_ADDR <= a;
    @(posedge CLK);
    REG_RD <= 1'b0;
    #1;
    chk(17'(REG_RDATA & m), 17'(e & m));
  endtask
  task automatic msg(input logic [15:0] c, input int n, input logic [15:0] d, input logic inv);
    txq.delete();
    en_cnt = 0;
    @(posedge CLK);
    CMD_VALID <= 1'b1;
    CMD_WORD <= c;
    CMD_INVALID <= inv;
    @(posedge CLK);
    CMD_VALID <= 1'b0;
    repeat (n) begin
      DATA_VALID <= 1'b1;
      DATA_WORD <= d;
      @(posedge CLK);
      DATA_VALID <= 1'b0;
      @(posedge CLK);
    end
    MSG_END <= 1'b1;
    @(posedge CLK);
    MSG_END <= 1'b0;
    CMD_INVALID <= 1'b0;
    repeat (14) @(posedge CLK);
  endtask
  task automatic tx(input int n, input logic [16:0] w0, input logic [16:0] w1);
    chk(17'(txq.size()), 17'(n));
    if (n > 0 && txq.size() > 0) chk(txq[0], w0);
    if (n > 1 && txq.size() > 1) chk(txq[1], w1);
  endtask
  task automatic stop_test;
    $display("checks=%0d mismatches=%0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // --------------------------------
  // scenarios
  // --------------------------------
  initial begin
    logic [15:0] c, eb, d;
    int          k, n, g;
    logic        br;
    repeat (20) @(posedge CLK);
    RST <= 1'b0;
    rchk(OFS_CONTROL, 16'h0001, 16'h001F);
    rchk(OFS_STATUS, sw(1'b0, 1'b0), 16'hFFFF);
    rchk(OFS_SELFTEST, 16'h0000, 16'hFFFF);
    rchk(8'h14, 16'h0000, 16'hFFFF);
    fin;
    vec = 16'($random(seed));
    msg(cw(RST_RT_ADDR, 1'b1, MC_VECTOR), 0, 16'h0000, 1'b0);
    tx(2, {1'b1, sw(1'b0, 1'b0)}, {1'b0, vec});
    msg(cw(RST_RT_ADDR, 1'b1, MC_SELFTEST), 0, 16'h0000, 1'b1);
    tx(0, 17'h00000, 17'h00000);
    rchk(OFS_LAST_CMD, cw(RST_RT_ADDR, 1'b1, MC_VECTOR), 16'hFFFF);
    fin;
    c = cw(RST_RT_ADDR, 1'b0, MC_VECTOR);
    msg(c, 0, 16'h0000, 1'b0);
    tx(0, 17'h00000, 17'h00000);
    rchk(OFS_STATUS, sw(1'b1, 1'b0), 16'hFFFF);
    rchk(OFS_SELFTEST, TRE | LWC, BW_ERR_MASK);
    msg(cw(RST_RT_ADDR, 1'b1, MC_LAST_CMD), 0, 16'h0000, 1'b0);
    tx(2, {1'b1, sw(1'b1, 1'b0)}, {1'b0, c});
    msg(cw(RST_RT_ADDR, 1'b1, MC_SELFTEST), 0, 16'h0000, 1'b0);
    tx(2, {1'b1, sw(1'b1, 1'b0)}, {1'b0, TRE | LWC});
    chk(17'(en_cnt), 17'h00001);
    chk(17'(test_latch), 17'(TRE | LWC));
    fin;
    d = 16'($random(seed));
    msg(cw(BCAST_ADDR, 1'b0, MC_SYNC_DATA), 1, d, 1'b0);
    tx(0, 17'h00000, 17'h00000);
    chk(17'(handed), 17'(d));
    rchk(OFS_STATUS, 16'h0010, 16'h0010);
    msg(cw(RST_RT_ADDR, 1'b1, MC_LAST_CMD), 1, d, 1'b0);
    tx(0, 17'h00000, 17'h00000);
    rchk(OFS_STATUS, sw(1'b1, 1'b0), 16'hFFFF);
    for (n = 0; n < 3; n += 2) begin
      msg(cw(RST_RT_ADDR, 1'b0, MC_SYNC_DATA), n, d, 1'b0);
      tx(0, 17'h00000, 17'h00000);
      rchk(OFS_SELFTEST, (n == 0) ? LWC : HWC, LWC | HWC);
    end
    msg(cw(RST_RT_ADDR, 1'b1, MC_SYNC_DATA), 1, d, 1'b0);
    rchk(OFS_SELFTEST, TRE | HWC, BW_ERR_MASK);
    fin;
    for (k = 0; k < 2; k++) begin
      d = 16'($random(seed));
      msg(cw(RST_RT_ADDR, 1'b0, MC_SHUTDOWN | 5'(k)), 1, d, 1'b0);
      chk(17'(txq.size()), 17'h00001);
      chk(17'(handed), 17'(d));
    end
    for (k = 0; k < 4; k++) begin
      n = (k < 2) ? 0 : 2;
      msg(cw(RST_RT_ADDR, 1'b0, MC_SHUTDOWN | 5'(k % 2)), n, d, 1'b0);
      tx(0, 17'h00000, 17'h00000);
      rchk(OFS_SELFTEST, ILL | (((k % 2) == (n == 0)) ? LWC : HWC), BW_ERR_MASK);
    end
    msg(cw(RST_RT_ADDR, 1'b1, 5'h1F), 0, 16'h0000, 1'b0);
    chk(17'(txq.size()), 17'h00001);
    fin;
    for (int i = 0; i < 12; i++) begin
      k = {$random(seed)} % 5;
      d = 16'($random(seed));
      br = (k < 2);
      n = (k == 2 || k == 3);
      eb = (k < 2) ? ILL : ILL | HWC;
      c = cw(BCAST_ADDR, 1'b1, (k == 0) ? MC_VECTOR : MC_SELFTEST);
      if (k == 2) c = cw(RST_RT_ADDR, 1'b1, MC_SHUTDOWN | 5'(i % 2));
      if (k > 2) c = cw(RST_RT_ADDR, k == 3, 5'h16 + 5'(i % 10));
      msg(c, n, d, 1'b0);
      tx(0, 17'h00000, 17'h00000);
      rchk(OFS_STATUS, sw(1'b1, br), 16'h0410);
      rchk(OFS_SELFTEST, eb, BW_ERR_MASK);
    end
    d = 16'($random(seed));
    wr(OFS_SELFTEST, d);
    rchk(OFS_SELFTEST, d, 16'hFFFF);
    fin;
    @(posedge CLK);
    HOST_ACCESS_STROBE_N <= 1'b0;
    g = 0;
    while (HOST_ACCESS_GRANT_N !== 1'b0 && g < 50) begin
      @(posedge CLK);
      #1;
      g++;
    end
    chk(17'(g), 17'(GRANT_CYCLES + 2));
    @(posedge CLK);
    #1;
    chk(17'(HOST_TRANSFER_DONE_N), 17'h00000);
    @(posedge CLK);
    HOST_ACCESS_STROBE_N <= 1'b1;
    repeat (3) @(posedge CLK);
    #1;
    chk(17'({HOST_ACCESS_GRANT_N, HOST_TRANSFER_DONE_N}), 17'h00003);
    fin;
    stop_test;
  end
  // a full run is well under a thousand cycles; this leaves wide margin
  initial begin
    #100000;
    err_total++;
    stop_test;
  end
endmodule // rtmc_mode_upper_tb
